// File: logic/rpc_classifier.sv
// Receive packet classifier with filter registers and verdict output
// Overview of operation
// - Compare IPv4 destination of Ethernet packets with first own address.
// - Second programmable IPv4 address also counts as own address.
// - Station MAC is low word register plus low half of control.
// - Location bit picks bundle id from UDP source (0) or destination (1).
// - Port check select: 00 off, 01 source port, 10 destination, 11 reserved.
// - CPU ethertype packets: switch 0 to CPU, 1 discard.
// - Pseudowire OAM packets: switch 0 to CPU, 1 discard.
// - Unknown bundle identifier: switch 0 to CPU, 1 discard.
// - Checked UDP port matching neither value: switch 0 CPU, 1 discard.
// - IP protocol neither UDP nor L2TPv3: switch 0 CPU, 1 discard.
// - ARP target matching own address: switch 0 CPU, 1 discard.
// - Ethertype not IP, MPLS or ARP: switch 0 CPU, 1 discard.
// - IP destination matching no own address: switch 0 CPU, 1 discard.
// - ARP target matching no own address: switch 0 CPU, 1 discard.
// - Two 16-bit pseudowire port values, both resetting to 085E hex.
// - Bundle id width mask selects identifier bits of the chosen port.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module rpc_classifier
	import rpc_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic rx_valid,
	input wire logic [15:0] rx_data,
	input wire logic rx_sop,
	input wire logic rx_eop,
	output logic rx_ready,
	output logic vd_valid,
	output logic [VD_W-1:0] vd_data,
	input wire logic vd_ready
);
	if (DEPTH < 2) begin : g_chk
		$error("rpc_classifier needs a verdict FIFO of at least two words");
	end

	typedef struct packed {
		rpc_state_t fsm;
		logic [4:0] wcnt;
		logic rx_ready;
		logic [31:0] ip1;
		logic [31:0] ip2;
		logic [31:0] ip3;
		logic [31:0] mac_low;
		logic [31:0] ctl;
		logic [31:0] pw_ports;
		logic [31:0] bundle_cfg;
		logic [15:0] id_mask;
		logic [15:0] cpu_etype;
		logic [47:0] dmac;
		logic [15:0] etype;
		logic [15:0] sport;
		logic [15:0] dport;
		logic [7:0] proto;
		logic [31:0] addr;
		logic [7:0] cnt_bundle;
		logic [7:0] cnt_cpu;
		logic [7:0] cnt_drop;
		logic [31:0] rdata;
		logic vd_valid;
		logic [VD_W-1:0] vd_data;
	} rpc_top_state_t;

	rpc_top_state_t st;
	rpc_top_state_t next_st;

	function automatic logic [1:0] rpc_sw(input logic sw);
		return sw ? ACT_DROP : ACT_CPU;
	endfunction : rpc_sw

	logic [47:0] station_mac;
	logic mac_ok;
	logic is_ip;
	logic is_arp;
	logic is_mpls;
	logic ip_hit;
	logic port_hit;
	logic port_chk;
	logic [1:0] psel;
	logic [15:0] port_key;
	logic [15:0] bundle_id;
	logic [1:0] act;
	rpc_reason_t rsn;
	logic [VD_W-1:0] verdict;
	logic push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [VD_W-1:0] fifo_out_data;
	logic acc;
	logic [4:0] idx;

	assign station_mac = {st.ctl[15:0], st.mac_low};
	assign mac_ok = (st.dmac == station_mac) || (&st.dmac);
	assign is_ip = (st.etype == ET_IP);
	assign is_arp = (st.etype == ET_ARP);
	assign is_mpls = (st.etype == ET_MPLS);
	assign psel = st.ctl[CTL_PSEL_LO +: 2];
	assign port_chk = (psel == PSEL_SRC) || (psel == PSEL_DST);
	assign port_key = (psel == PSEL_SRC) ? st.sport : st.dport;
	assign bundle_id = (st.ctl[CTL_ID_SEL] ? st.dport : st.sport) & st.id_mask;
	assign push = (st.fsm == RPC_DECIDE) && fifo_in_ready;
	assign verdict = {act, rsn, bundle_id};
	assign fifo_out_ready = !st.vd_valid || vd_ready;
	assign acc = rx_valid && st.rx_ready;
	assign idx = (st.fsm == RPC_IDLE) ? W_DMAC0 : st.wcnt;

	// Own addresses: first, second and third
	rpc_match #(
		.W(32),
		.N(3)
	) u_ip_match (
		.key(st.addr),
		.values({st.ip3, st.ip2, st.ip1}),
		.hit(ip_hit)
	);

	// Pseudowire UDP port values
	rpc_match #(
		.W(16),
		.N(2)
	) u_port_match (
		.key(port_key),
		.values(st.pw_ports),
		.hit(port_hit)
	);

	rpc_fifo #(
		.WIDTH(VD_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(verdict),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Classification of the captured header
	always_comb begin
		act = ACT_CPU;
		rsn = RSN_MPLS;
		if (!mac_ok) begin
			act = ACT_DROP;
			rsn = RSN_MAC_MISS;
		end else if (is_arp) begin
			if (ip_hit) begin
				act = rpc_sw(st.ctl[CTL_SW0 + 3]);
				rsn = RSN_ARP_HIT;
			end else begin
				act = rpc_sw(st.ctl[CTL_SW0]);
				rsn = RSN_ARP_MISS;
			end
		end else if (is_mpls) begin
			act = ACT_CPU;
			rsn = RSN_MPLS;
		end else if (!is_ip) begin
			if (st.etype == st.cpu_etype) begin
				act = rpc_sw(st.ctl[CTL_SW0 + 8]);
				rsn = RSN_CPU_ETYPE;
			end else begin
				act = rpc_sw(st.ctl[CTL_SW0 + 2]);
				rsn = RSN_OTHER_ETYPE;
			end
		end else if (!ip_hit) begin
			act = rpc_sw(st.ctl[CTL_SW0 + 1]);
			rsn = RSN_IP_MISS;
		end else if (st.proto == PROTO_L2TP) begin
			act = ACT_CPU;
			rsn = RSN_L2TP;
		end else if (st.proto != PROTO_UDP) begin
			act = rpc_sw(st.ctl[CTL_SW0 + 4]);
			rsn = RSN_IP_PROTO;
		end else if (port_chk && !port_hit) begin
			act = rpc_sw(st.ctl[CTL_SW0 + 5]);
			rsn = RSN_UDP_PORT;
		end else if (bundle_id == st.bundle_cfg[15:0]) begin
			act = rpc_sw(st.ctl[CTL_SW0 + 7]);
			rsn = RSN_OAM;
		end else if (bundle_id == st.bundle_cfg[31:16]) begin
			act = ACT_BUNDLE;
			rsn = RSN_BUNDLE;
		end else begin
			act = rpc_sw(st.ctl[CTL_SW0 + 6]);
			rsn = RSN_UNK_BUNDLE;
		end
	end

	always_comb begin
		next_st = st;
		next_st.rdata = '0;
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				OFS_IP_FIRST: next_st.ip1 = reg_wdata;
				OFS_IP_SECOND: next_st.ip2 = reg_wdata;
				OFS_MAC_LOW: next_st.mac_low = reg_wdata;
				OFS_CTL: next_st.ctl = reg_wdata & CTL_WMASK;
				OFS_PW_PORTS: next_st.pw_ports = reg_wdata;
				OFS_ID_MASK: next_st.id_mask = reg_wdata[31:FIELD_HI_LO];
				OFS_CPU_ETYPE: next_st.cpu_etype = reg_wdata[31:FIELD_HI_LO];
				OFS_IP_THIRD: next_st.ip3 = reg_wdata;
				OFS_BUNDLE: next_st.bundle_cfg = reg_wdata;
				default: ;
			endcase
		end
		// Register reads, data in the following cycle
		if (reg_rd) begin
			case (reg_addr)
				OFS_IP_FIRST: next_st.rdata = st.ip1;
				OFS_IP_SECOND: next_st.rdata = st.ip2;
				OFS_MAC_LOW: next_st.rdata = st.mac_low;
				OFS_CTL: next_st.rdata = st.ctl;
				OFS_PW_PORTS: next_st.rdata = st.pw_ports;
				OFS_ID_MASK: next_st.rdata = {st.id_mask, 16'h0000};
				OFS_CPU_ETYPE: next_st.rdata = {st.cpu_etype, 16'h0000};
				OFS_IP_THIRD: next_st.rdata = st.ip3;
				OFS_BUNDLE: next_st.rdata = st.bundle_cfg;
				OFS_STATUS: next_st.rdata = {8'h00, st.cnt_drop, st.cnt_cpu, st.cnt_bundle};
				default: next_st.rdata = '0;
			endcase
		end
		// Header capture
		if (acc && (st.fsm != RPC_IDLE || rx_sop)) begin
			if (idx != 5'h1F) begin
				next_st.wcnt = 5'(idx + 5'h01);
			end
			case (idx)
				W_DMAC0: begin
					next_st.dmac[47:32] = rx_data;
					next_st.etype = '0;
					next_st.proto = '0;
					next_st.addr = '0;
					next_st.sport = '0;
					next_st.dport = '0;
				end
				W_DMAC1: next_st.dmac[31:16] = rx_data;
				W_DMAC2: next_st.dmac[15:0] = rx_data;
				W_ETYPE: next_st.etype = rx_data;
				W_PROTO: next_st.proto = rx_data[7:0];
				W_IPDST_HI: if (is_ip) next_st.addr[31:16] = rx_data;
				W_IPDST_LO: if (is_ip) next_st.addr[15:0] = rx_data;
				W_SPORT: next_st.sport = rx_data;
				W_DPORT: next_st.dport = rx_data;
				W_TPA_HI: if (is_arp) next_st.addr[31:16] = rx_data;
				W_TPA_LO: if (is_arp) next_st.addr[15:0] = rx_data;
				default: ;
			endcase
		end
		// Packet sequencing
		case (st.fsm)
			RPC_IDLE: begin
				if (acc && rx_sop) begin
					next_st.fsm = rx_eop ? RPC_DECIDE : RPC_BODY;
				end
			end
			RPC_BODY: begin
				if (acc && rx_eop) begin
					next_st.fsm = RPC_DECIDE;
				end
			end
			RPC_DECIDE: begin
				if (fifo_in_ready) begin
					next_st.fsm = RPC_IDLE;
					case (act)
						ACT_BUNDLE: next_st.cnt_bundle = 8'(st.cnt_bundle + 8'h01);
						ACT_CPU: next_st.cnt_cpu = 8'(st.cnt_cpu + 8'h01);
						default: next_st.cnt_drop = 8'(st.cnt_drop + 8'h01);
					endcase
				end
			end
			default: next_st.fsm = RPC_IDLE;
		endcase
		next_st.rx_ready = (next_st.fsm != RPC_DECIDE);
		// Output stage
		if (fifo_out_valid && fifo_out_ready) begin
			next_st.vd_valid = 1'b1;
			next_st.vd_data = fifo_out_data;
		end else if (vd_ready) begin
			next_st.vd_valid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.rx_ready <= 1'b1;
			st.pw_ports <= {RST_PW_PORT, RST_PW_PORT};
			st.cpu_etype <= RST_CPU_ETYPE;
			st.bundle_cfg <= RST_BUNDLE_CFG;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign rx_ready = st.rx_ready;
	assign vd_valid = st.vd_valid;
	assign vd_data = st.vd_data;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	ip_first_hit_a: assert property (
		push && mac_ok && is_ip && st.addr == st.ip1 |-> rsn != RSN_IP_MISS
	) else $error("first own address not recognised");
	ip_second_hit_a: assert property (
		push && mac_ok && is_ip && st.addr == st.ip2 |-> rsn != RSN_IP_MISS
	) else $error("second own address not recognised");
	mac_assembly_a: assert property (
		push && st.dmac == {st.ctl[15:0], st.mac_low} |-> rsn != RSN_MAC_MISS
	) else $error("station address not assembled from both registers");
	bundle_select_a: assert property (
		push && rsn == RSN_BUNDLE |-> verdict[15:0] == ((st.ctl[27] ? st.dport : st.sport) & st.id_mask)
	) else $error("bundle id taken from wrong port or mask");
	port_check_a: assert property (
		push && mac_ok && is_ip && ip_hit && st.proto == PROTO_UDP && st.ctl[26:25] == 2'b01
		&& st.sport != st.pw_ports[15:0] && st.sport != st.pw_ports[31:16] |-> rsn == RSN_UDP_PORT
	) else $error("source port check missed");
	cpu_etype_a: assert property (
		push && rsn == RSN_CPU_ETYPE |-> act == (st.ctl[24] ? ACT_DROP : ACT_CPU)
	) else $error("cpu ethertype switch not obeyed");
	oam_switch_a: assert property (
		push && rsn == RSN_OAM |-> act == (st.ctl[23] ? ACT_DROP : ACT_CPU)
	) else $error("oam switch not obeyed");
	unk_bundle_a: assert property (
		push && rsn == RSN_UNK_BUNDLE |-> act == (st.ctl[22] ? ACT_DROP : ACT_CPU)
	) else $error("unknown bundle switch not obeyed");
	udp_port_a: assert property (
		push && rsn == RSN_UDP_PORT |-> act == (st.ctl[21] ? ACT_DROP : ACT_CPU)
	) else $error("udp port switch not obeyed");
	ip_miss_a: assert property (
		push && mac_ok && is_ip && st.addr != st.ip1 && st.addr != st.ip2 && st.addr != st.ip3
		|-> rsn == RSN_IP_MISS && act == (st.ctl[17] ? ACT_DROP : ACT_CPU)
	) else $error("foreign ip destination not filtered");
	arp_hit_a: assert property (
		push && rsn == RSN_ARP_HIT |-> act == (st.ctl[19] ? ACT_DROP : ACT_CPU)
	) else $error("arp hit switch not obeyed");
	port_reset_a: assert property (
		$past(rst) |-> st.pw_ports == 32'h085E_085E
	) else $error("pseudowire ports not at reset value");
	verdict_hold_a: assert property (
		vd_valid && !vd_ready |=> vd_valid && $stable(vd_data)
	) else $error("verdict dropped while stalled");
	push_delivery_a: assert property (
		push && !fifo_out_valid && !st.vd_valid |-> ##2 vd_valid && vd_data == $past(verdict, 2)
	) else $error("verdict not delivered in two cycles");
	read_once_a: assert property (
		!reg_rd |=> reg_rdata == 32'h0000_0000
	) else $error("read data present without a read");
endmodule : rpc_classifier

// File: include/rpc_pkg.sv
// Shared constants and types of the receive packet classifier
package rpc_pkg;
	localparam logic [7:0] OFS_IP_FIRST = 8'h38;
	localparam logic [7:0] OFS_IP_SECOND = 8'h3C;
	localparam logic [7:0] OFS_MAC_LOW = 8'h40;
	localparam logic [7:0] OFS_CTL = 8'h44;
	localparam logic [7:0] OFS_PW_PORTS = 8'h48;
	localparam logic [7:0] OFS_ID_MASK = 8'h50;
	localparam logic [7:0] OFS_CPU_ETYPE = 8'h54;
	localparam logic [7:0] OFS_IP_THIRD = 8'h58;
	localparam logic [7:0] OFS_BUNDLE = 8'h80;
	localparam logic [7:0] OFS_STATUS = 8'h84;
	localparam int CTL_ID_SEL = 27;
	localparam int CTL_PSEL_LO = 25;
	localparam int CTL_SW0 = 16;
	localparam int FIELD_HI_LO = 16;
	localparam logic [31:0] CTL_WMASK = 32'h1FFF_FFFF;
	localparam logic [15:0] RST_PW_PORT = 16'h085E;
	localparam logic [15:0] RST_CPU_ETYPE = 16'h0800;
	localparam logic [31:0] RST_BUNDLE_CFG = 32'h0001_FFFF;
	localparam logic [15:0] ET_IP = 16'h0800;
	localparam logic [15:0] ET_ARP = 16'h0806;
	localparam logic [15:0] ET_MPLS = 16'h8847;
	localparam logic [7:0] PROTO_UDP = 8'h11;
	localparam logic [7:0] PROTO_L2TP = 8'h73;
	localparam logic [4:0] W_DMAC0 = 5'h00;
	localparam logic [4:0] W_DMAC1 = 5'h01;
	localparam logic [4:0] W_DMAC2 = 5'h02;
	localparam logic [4:0] W_ETYPE = 5'h06;
	localparam logic [4:0] W_PROTO = 5'h0B;
	localparam logic [4:0] W_IPDST_HI = 5'h0F;
	localparam logic [4:0] W_IPDST_LO = 5'h10;
	localparam logic [4:0] W_SPORT = 5'h11;
	localparam logic [4:0] W_DPORT = 5'h12;
	localparam logic [4:0] W_TPA_HI = 5'h13;
	localparam logic [4:0] W_TPA_LO = 5'h14;
	localparam logic [1:0] PSEL_SRC = 2'h1;
	localparam logic [1:0] PSEL_DST = 2'h2;
	localparam logic [1:0] ACT_DROP = 2'h0;
	localparam logic [1:0] ACT_CPU = 2'h1;
	localparam logic [1:0] ACT_BUNDLE = 2'h2;
	typedef enum logic [3:0] {
		RSN_BUNDLE = 4'h0, RSN_CPU_ETYPE = 4'h1, RSN_OAM = 4'h2, RSN_UNK_BUNDLE = 4'h3,
		RSN_UDP_PORT = 4'h4, RSN_IP_PROTO = 4'h5, RSN_ARP_HIT = 4'h6, RSN_OTHER_ETYPE = 4'h7,
		RSN_IP_MISS = 4'h8, RSN_ARP_MISS = 4'h9, RSN_MAC_MISS = 4'hA, RSN_MPLS = 4'hB,
		RSN_L2TP = 4'hC
	} rpc_reason_t;
	localparam int VD_W = 22;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [1:0] {RPC_IDLE = 2'b00, RPC_BODY = 2'b01, RPC_DECIDE = 2'b11} rpc_state_t;
endpackage : rpc_pkg

// File: logic/rpc_match.sv
// Equality match of a key against a packed list of values
`timescale 1ns/1ps
module rpc_match #(
	parameter int W = 32,
	parameter int N = 3
) (
	input wire logic [W-1:0] key,
	input wire logic [N*W-1:0] values,
	output logic hit
);
	logic [N-1:0] eq;
	if (N < 1 || W < 1) begin : g_chk
		$error("rpc_match needs N and W of at least one");
	end
	for (genvar i = 0; i < N; i++) begin : g_eq
		assign eq[i] = (values[i*W +: W] == key);
	end
	assign hit = |eq;
endmodule : rpc_match

// File: logic/rpc_fifo.sv
// Verdict FIFO with valid and ready on both sides
`timescale 1ns/1ps
module rpc_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("rpc_fifo depth must be a power of two of at least two");
	end
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} rpc_fifo_state_t;
	rpc_fifo_state_t st;
	rpc_fifo_state_t next_st;
	assign in_ready = ((st.wp ^ st.rp) != {1'b1, {AW{1'b0}}});
	assign out_valid = (st.wp != st.rp);
	assign out_data = st.mem[st.rp[AW-1:0]];
	always_comb begin
		next_st = st;
		if (in_valid && in_ready) begin
			next_st.mem[st.wp[AW-1:0]] = in_data;
			next_st.wp = st.wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			next_st.rp = st.rp + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : rpc_fifo

// File: dv/rpc_mac_model.sv
// Receive stream source standing in for the Ethernet MAC
`timescale 1ns/1ps
module rpc_mac_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [15:0] pkt [0:20],
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [15:0] rx_data,
	output logic rx_sop,
	output logic rx_eop,
	output logic busy
);
	logic [4:0] idx;
	logic [15:0] last;
	// Idle data line shows the inverse of the last word
	assign rx_data = rx_valid ? pkt[idx] : ~last;
	assign rx_sop = rx_valid && idx == 5'h00;
	assign rx_eop = rx_valid && idx == 5'h14;
	assign busy = rx_valid;
	// Word held until taken; next start two cycles after the end at the soonest
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_valid <= 1'b0;
			idx <= 5'h00;
			last <= 16'h0000;
		end else if (!rx_valid) begin
			rx_valid <= start;
			idx <= 5'h00;
		end else if (rx_ready) begin
			last <= rx_data;
			idx <= idx + 5'h01;
			rx_valid <= !rx_eop;
		end
	end
endmodule : rpc_mac_model

// File: dv/testbench.sv
// Self-checking bench of the receive packet classifier
`timescale 1ns/1ps
module testbench
	import rpc_pkg::*;
;
	typedef struct {
		logic [15:0] hi;
		logic [15:0] sw;
		logic [15:0] et;
		logic [7:0] pr;
		logic [7:0] ip;
		logic [15:0] sp;
		logic [15:0] dp;
		logic bad;
		rpc_reason_t rsn;
	} rpc_row_t;
	logic clk, rst, reg_wr, reg_rd, rx_valid, rx_sop, rx_eop, rx_ready, vd_valid, vd_ready, start, busy;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] rx_data;
	logic [VD_W-1:0] vd_data;
	logic [15:0] pkt [0:20];
	rpc_row_t rows [0:15];
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	rpc_classifier #(.DEPTH(FIFO_DEPTH)) u_rpc_classifier (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_ready(rx_ready), .vd_valid(vd_valid),
		.vd_data(vd_data), .vd_ready(vd_ready));
	rpc_mac_model u_rpc_mac_model (.clk(clk), .rst(rst), .start(start), .pkt(pkt), .rx_ready(rx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_sop(rx_sop), .rx_eop(rx_eop), .busy(busy));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e);
		@(posedge clk);
		#1;
		check(reg_rdata, 32'h0000_0000);
	endtask : rchk
	task automatic mk(input logic [15:0] et, input logic [7:0] pr, input logic [7:0] ip,
		input logic [15:0] sp, input logic [15:0] dp, input logic bad);
		for (int k = 0; k < 21; k++)
			pkt[k] = 16'h0000;
		pkt[0] = bad ? 16'h0102 : 16'h1122;
		pkt[1] = 16'h3344;
		pkt[2] = 16'h5566;
		pkt[6] = et;
		pkt[11] = {8'h40, pr};
		pkt[15] = 16'h0A00;
		pkt[16] = {8'h00, ip};
		pkt[17] = sp;
		pkt[18] = dp;
		pkt[19] = 16'h0A00;
		pkt[20] = {8'h00, ip};
	endtask : mk
	task automatic send(output logic ok);
		ok = 1'b0;
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int k = 0; k < 60 && !ok; k++) begin
			@(posedge clk);
			#1;
			ok = !busy;
		end
	endtask : send
	task automatic get_vd(output logic [21:0] v);
		for (int k = 0; k < 60 && vd_valid !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		check(32'(vd_valid), 32'h0000_0001);
		v = vd_data;
		@(posedge clk);
		#1;
	endtask : get_vd
	initial begin
		logic [1:0] act;
		logic [21:0] v;
		logic ok;
		int n;
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		start = 1'b0;
		vd_ready = 1'b1;
		mk(16'h0800, 8'h11, 8'h01, 16'h1205, 16'h3307, 1'b0);
		rows[0] = '{16'h0000, 16'h0000, 16'h0800, 8'h11, 8'h01, 16'h1205, 16'h3307, 1'b0, RSN_BUNDLE};
		rows[1] = '{16'h0800, 16'h0080, 16'h0800, 8'h11, 8'h02, 16'h1205, 16'h3307, 1'b0, RSN_OAM};
		rows[2] = '{16'h0000, 16'h0040, 16'h0800, 8'h11, 8'h01, 16'h1209, 16'h3307, 1'b0, RSN_UNK_BUNDLE};
		rows[3] = '{16'h0200, 16'h0020, 16'h0800, 8'h11, 8'h01, 16'h1205, 16'h3307, 1'b0, RSN_UDP_PORT};
		rows[4] = '{16'h0400, 16'h0000, 16'h0800, 8'h11, 8'h01, 16'h1205, 16'h085E, 1'b0, RSN_BUNDLE};
		rows[5] = '{16'h0A00, 16'h0000, 16'h0800, 8'h11, 8'h01, 16'h085E, 16'h3305, 1'b0, RSN_BUNDLE};
		rows[6] = '{16'h0600, 16'h0000, 16'h0800, 8'h11, 8'h01, 16'h1205, 16'h3307, 1'b0, RSN_BUNDLE};
		rows[7] = '{16'h0000, 16'h0010, 16'h0800, 8'h06, 8'h01, 16'h1205, 16'h3307, 1'b0, RSN_IP_PROTO};
		rows[8] = '{16'h0000, 16'h0002, 16'h0800, 8'h11, 8'h99, 16'h1205, 16'h3307, 1'b0, RSN_IP_MISS};
		rows[9] = '{16'h0000, 16'h0008, 16'h0806, 8'h00, 8'h01, 16'h0000, 16'h0000, 1'b0, RSN_ARP_HIT};
		rows[10] = '{16'h0000, 16'h0001, 16'h0806, 8'h00, 8'hFF, 16'h0000, 16'h0000, 1'b0, RSN_ARP_MISS};
		rows[11] = '{16'h0000, 16'h0004, 16'h88B5, 8'h00, 8'h01, 16'h0000, 16'h0000, 1'b0, RSN_OTHER_ETYPE};
		rows[12] = '{16'h0000, 16'h0100, 16'h9000, 8'h00, 8'h01, 16'h0000, 16'h0000, 1'b0, RSN_CPU_ETYPE};
		rows[13] = '{16'h0000, 16'h0000, 16'h0800, 8'h11, 8'h01, 16'h1205, 16'h3307, 1'b1, RSN_MAC_MISS};
		rows[14] = '{16'h0000, 16'h0000, 16'h8847, 8'h00, 8'h01, 16'h0000, 16'h0000, 1'b0, RSN_MPLS};
		rows[15] = '{16'h0000, 16'h0000, 16'h0800, 8'h73, 8'h01, 16'h1205, 16'h3307, 1'b0, RSN_L2TP};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(32'(rx_ready), 32'h0000_0001);
		rchk(OFS_PW_PORTS, 32'h085E_085E);
		rchk(OFS_CPU_ETYPE, 32'h0800_0000);
		rchk(OFS_CTL, 32'h0000_0000);
		rchk(OFS_IP_FIRST, 32'h0000_0000);
		rchk(8'h70, 32'h0000_0000);
		wr(OFS_IP_FIRST, 32'h0A00_0001);
		wr(OFS_IP_SECOND, 32'h0A00_0002);
		wr(OFS_IP_THIRD, 32'h0A00_0001);
		wr(OFS_MAC_LOW, 32'h3344_5566);
		wr(OFS_ID_MASK, 32'h00FF_0000);
		wr(OFS_CPU_ETYPE, 32'h9000_0000);
		wr(OFS_BUNDLE, 32'h0005_0007);
		rchk(OFS_IP_SECOND, 32'h0A00_0002);
		wr(OFS_CTL, 32'h0FFF_FFFF);
		rchk(OFS_CTL, 32'h0FFF_FFFF);
		rchk(OFS_MAC_LOW, 32'h3344_5566);
		for (int i = 0; i < 16; i++) begin
			for (int p = 0; p < 2; p++) begin
				wr(OFS_CTL, {rows[i].hi | (p == 1 ? rows[i].sw : 16'h0000), 16'h1122});
				mk(rows[i].et, rows[i].pr, rows[i].ip, rows[i].sp, rows[i].dp, rows[i].bad);
				send(ok);
				get_vd(v);
				if (rows[i].rsn == RSN_BUNDLE)
					act = ACT_BUNDLE;
				else if (rows[i].rsn == RSN_MAC_MISS || (p == 1 && rows[i].sw != 16'h0000))
					act = ACT_DROP;
				else
					act = ACT_CPU;
				check(32'(v[21:16]), 32'({act, rows[i].rsn}));
				if (act == ACT_BUNDLE)
					check(32'(v[15:0]), 32'h0000_0005);
			end
		end
		// Drop, cpu and bundle counts of the table
		rchk(OFS_STATUS, 32'h000B_0D08);
		// Verdict sink stalls until the buffer refuses
		@(posedge clk);
		vd_ready <= 1'b0;
		wr(OFS_CTL, 32'h0000_1122);
		n = 0;
		ok = 1'b1;
		while (ok && n < 40) begin
			mk(16'h0800, 8'h11, (n % 2 == 1) ? 8'h99 : 8'h01, 16'h1205, 16'h3307, 1'b0);
			send(ok);
			if (ok)
				n++;
		end
		check(32'(rx_ready), 32'h0000_0000);
		// Output stage, full buffer and one held in decide
		check(32'(n), 32'(FIFO_DEPTH + 2));
		check(32'(vd_data[19:16]), 32'(RSN_BUNDLE));
		@(posedge clk);
		vd_ready <= 1'b1;
		#1;
		for (int j = 0; j <= n; j++) begin
			get_vd(v);
			check(32'(v[19:16]), 32'((j % 2 == 1) ? RSN_IP_MISS : RSN_BUNDLE));
		end
		check(32'(vd_valid), 32'h0000_0000);
		// Reset in mid-run
		wr(OFS_IP_FIRST, 32'h1234_5678);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(32'(vd_valid), 32'h0000_0000);
		check(32'(rx_ready), 32'h0000_0001);
		rchk(OFS_IP_FIRST, 32'h0000_0000);
		rchk(OFS_PW_PORTS, 32'h085E_085E);
		rchk(OFS_STATUS, 32'h0000_0000);
		print_verdict();
	end
endmodule : testbench
